/* File: design/fupc_byte_reg.sv */
/*
  One 8-bit read/write register byte with asynchronous reset to a constant.
  Assumes write strobe and data come from the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fupc_byte_reg (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic wr_en_in,
  input wire logic [7:0] wr_data_in,
  output logic [7:0] value_out
);
  logic [7:0] value_reg;
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      value_reg <= fupc_pkg::FUPC_RESET_BYTE; // [RULE_08]
    end else if (wr_en_in) begin
      value_reg <= wr_data_in;
    end
  end
  assign value_out = value_reg;
endmodule
`default_nettype wire

/* File: design/fupc_pkg.sv */
/*
  Constants for the flash user program control block: register addresses,
  field positions, mode codes, key pattern and reset values.
  Assumes the CPU register file presents 8-bit addresses in set 1, bank 1.
*/
// Operation
// RULE_01: mode field bits 7..4: 0101 program, 1010 erase, 0110 hard-lock, else unused.
// RULE_02: control bit 0 starts an operation only in erase or hard-lock mode.
// RULE_03: writing 1 to start begins operation; hardware clears it; 0 means idle.
// RULE_04: sector pointer upper byte comes from the high-byte register.
// RULE_05: sector pointer lower byte comes from the low-byte register.
// RULE_06: user programming disabled unless key register holds the enabling pattern.
// RULE_07: software writes 10100101B to enable, any other value to disable.
// RULE_08: reset clears both sector registers and the key register to zero.
// RULE_09: these registers respond only to register addressing mode accesses.
// RULE_10: hard-lock is a protection mode; once started flash stays protected.
// RULE_11: start is ignored with an unused mode code or programming disabled.
package fupc_pkg;
  localparam logic [7:0] FUPC_ADDR_SEC_HIGH = 8'hEC;
  localparam logic [7:0] FUPC_ADDR_SEC_LOW = 8'hED;
  localparam logic [7:0] FUPC_ADDR_KEY = 8'hEE;
  localparam logic [7:0] FUPC_ADDR_CTRL = 8'hEF;
  localparam logic [7:0] FUPC_KEY_ENABLE = 8'hA5;
  localparam logic [7:0] FUPC_RESET_BYTE = 8'h00;
  localparam logic [3:0] FUPC_MODE_PROGRAM = 4'h5;
  localparam logic [3:0] FUPC_MODE_ERASE = 4'hA;
  localparam logic [3:0] FUPC_MODE_HARD_LOCK = 4'h6;
  localparam logic [3:0] FUPC_MODE_RESET = 4'h0;
  localparam int FUPC_MODE_MSB = 7;
  localparam int FUPC_MODE_LSB = 4;
  localparam int FUPC_START_BIT = 0;
  localparam int FUPC_OP_CYCLES = 4;
  localparam logic [7:0] FUPC_OP_CYCLES_W = 8'h04;
  typedef enum logic [1:0] {
    FUPC_OP_NONE,
    FUPC_OP_ERASE,
    FUPC_OP_LOCK
  } fupc_op_t;
endpackage

/* File: design/fupc_top.sv */
/*
  Flash user program control: mode/start control register, 16-bit sector
  pointer and user programming key, reached through the CPU register file.
  Assumes the core asserts reg_mode_in only for register addressing mode,
  bank1_sel_in when set 1 bank 1 is selected, and that the flash array
  acknowledges an operation with flash_done_in (same clock domain).
*/
`timescale 1ns/1ps
`default_nettype none
module fupc_top (
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_mode_in,
  input wire logic bank1_sel_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic flash_done_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_hit_out,
  output logic [15:0] sector_addr_out,
  output logic [3:0] mode_out,
  output logic prog_enable_out,
  output logic erase_start_out,
  output logic lock_start_out,
  output logic busy_out,
  output logic locked_out
);
  logic access_ok;
  logic wr_high;
  logic wr_low;
  logic wr_key;
  logic wr_ctrl;
  logic [7:0] sec_high;
  logic [7:0] sec_low;
  logic [7:0] key_val;
  logic [3:0] mode_reg;
  logic start_reg;
  logic locked_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] wr_mode;
  logic start_ok;
  logic [7:0] op_cnt_reg;
  fupc_pkg::fupc_op_t op_reg;
  logic launch;

  // indirect and other addressing forms never reach these registers
  assign access_ok = reg_mode_in && bank1_sel_in; // [RULE_09]
  assign wr_high = access_ok && reg_wr_in && (reg_addr_in == fupc_pkg::FUPC_ADDR_SEC_HIGH);
  assign wr_low = access_ok && reg_wr_in && (reg_addr_in == fupc_pkg::FUPC_ADDR_SEC_LOW);
  assign wr_key = access_ok && reg_wr_in && (reg_addr_in == fupc_pkg::FUPC_ADDR_KEY);
  assign wr_ctrl = access_ok && reg_wr_in && (reg_addr_in == fupc_pkg::FUPC_ADDR_CTRL);
  assign reg_hit_out = access_ok && (reg_wr_in || reg_rd_in) &&
    (reg_addr_in[7:2] == fupc_pkg::FUPC_ADDR_SEC_HIGH[7:2]);

  fupc_byte_reg u_sec_high (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_high),
    .wr_data_in(reg_wdata_in),
    .value_out(sec_high)
  );
  fupc_byte_reg u_sec_low (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_low),
    .wr_data_in(reg_wdata_in),
    .value_out(sec_low)
  );
  fupc_byte_reg u_key (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .wr_en_in(wr_key),
    .wr_data_in(reg_wdata_in),
    .value_out(key_val)
  );

  assign sector_addr_out = {sec_high, sec_low}; // [RULE_04] [RULE_05]
  // only the exact key enables; software relies on writing the pattern
  assign prog_enable_out = (key_val == fupc_pkg::FUPC_KEY_ENABLE); // [RULE_06] [RULE_07]
  assign mode_out = mode_reg;

  assign wr_mode = reg_wdata_in[fupc_pkg::FUPC_MODE_MSB:fupc_pkg::FUPC_MODE_LSB];
  // start only for erase/lock, valid key, not already running, not locked
  assign start_ok = prog_enable_out && !start_reg &&
    ((wr_mode == fupc_pkg::FUPC_MODE_ERASE) ||
     (wr_mode == fupc_pkg::FUPC_MODE_HARD_LOCK && !locked_reg) ||
     (wr_mode == fupc_pkg::FUPC_MODE_ERASE && !locked_reg)); // [RULE_02] [RULE_11]
  assign launch = wr_ctrl && reg_wdata_in[fupc_pkg::FUPC_START_BIT] && start_ok &&
    !(locked_reg && wr_mode == fupc_pkg::FUPC_MODE_ERASE); // [RULE_03] [RULE_10]

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_reg <= fupc_pkg::FUPC_MODE_RESET;
    end else if (wr_ctrl && !start_reg) begin
      // mode frozen while an operation runs
      mode_reg <= wr_mode; // [RULE_01]
    end
  end

  // operation sequencer: start bit stays set until done or timeout
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      start_reg <= 1'b0;
      op_reg <= fupc_pkg::FUPC_OP_NONE;
      op_cnt_reg <= 8'h00;
    end else if (launch) begin
      start_reg <= 1'b1;
      op_cnt_reg <= fupc_pkg::FUPC_OP_CYCLES_W;
      if (wr_mode == fupc_pkg::FUPC_MODE_HARD_LOCK) begin
        op_reg <= fupc_pkg::FUPC_OP_LOCK;
      end else begin
        op_reg <= fupc_pkg::FUPC_OP_ERASE;
      end
    end else if (start_reg) begin
      case (op_reg)
        fupc_pkg::FUPC_OP_ERASE, fupc_pkg::FUPC_OP_LOCK: begin
          if (flash_done_in || op_cnt_reg == 8'h01) begin
            start_reg <= 1'b0; // [RULE_03]
            op_reg <= fupc_pkg::FUPC_OP_NONE;
            op_cnt_reg <= 8'h00;
          end else begin
            op_cnt_reg <= op_cnt_reg - 8'h01;
          end
        end
        default: begin
          start_reg <= 1'b0;
          op_reg <= fupc_pkg::FUPC_OP_NONE;
        end
      endcase
    end
  end

  // protection persists until reset; no write path clears it
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      locked_reg <= 1'b0;
    end else if (launch && wr_mode == fupc_pkg::FUPC_MODE_HARD_LOCK) begin
      locked_reg <= 1'b1; // [RULE_10]
    end
  end

  assign busy_out = start_reg;
  assign locked_out = locked_reg;
  assign erase_start_out = start_reg && (op_reg == fupc_pkg::FUPC_OP_ERASE);
  assign lock_start_out = start_reg && (op_reg == fupc_pkg::FUPC_OP_LOCK);

  always_comb begin
    rdata_next = 8'h00;
    if (access_ok && reg_rd_in) begin
      case (reg_addr_in)
        fupc_pkg::FUPC_ADDR_SEC_HIGH: rdata_next = sec_high;
        fupc_pkg::FUPC_ADDR_SEC_LOW: rdata_next = sec_low;
        fupc_pkg::FUPC_ADDR_KEY: rdata_next = key_val;
        fupc_pkg::FUPC_ADDR_CTRL: rdata_next = {mode_reg, 3'h0, start_reg};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata_out = rdata_reg;

  // sequencer checks: launch, timeout window and self clear
  a_start_clears: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_03]
    $rose(start_reg) |-> ##[1:4] !start_reg)
    else $error("start bit not cleared");

  a_done_clears: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_03]
    (start_reg && flash_done_in) |=> !start_reg)
    else $error("done did not clear start");

  a_launch_sets: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_03]
    launch |=> start_reg)
    else $error("launch did not set start");

  a_cnt_range: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_03]
    start_reg |-> (op_cnt_reg != 8'h00 && op_cnt_reg <= fupc_pkg::FUPC_OP_CYCLES_W))
    else $error("op counter out of range");

  a_start_one_op: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_03]
    start_reg |-> (erase_start_out ^ lock_start_out))
    else $error("running without one operation");

  a_idle_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_03]
    $fell(start_reg) |-> (!erase_start_out && !lock_start_out))
    else $error("operation strobe after clear");

  // gating of the start bit by key and mode
  a_start_needs_key: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_06]
    $rose(start_reg) |-> $past(key_val) == fupc_pkg::FUPC_KEY_ENABLE)
    else $error("start without key");

  a_key_write: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_06]
    wr_key |=> prog_enable_out == ($past(reg_wdata_in) == fupc_pkg::FUPC_KEY_ENABLE))
    else $error("key decode wrong");

  a_start_mode_ok: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_02]
    $rose(start_reg) |-> ($past(wr_mode) == fupc_pkg::FUPC_MODE_ERASE ||
      $past(wr_mode) == fupc_pkg::FUPC_MODE_HARD_LOCK))
    else $error("start in wrong mode");

  // programming mode has no start function
  a_prog_no_start: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_02]
    (wr_ctrl && wr_mode == fupc_pkg::FUPC_MODE_PROGRAM && !start_reg) |=> !start_reg)
    else $error("program mode started");

  a_unused_ignored: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_11]
    (wr_ctrl && reg_wdata_in[fupc_pkg::FUPC_START_BIT] &&
      wr_mode != fupc_pkg::FUPC_MODE_ERASE && wr_mode != fupc_pkg::FUPC_MODE_HARD_LOCK &&
      !start_reg) |=> !start_reg)
    else $error("unused mode started");

  a_no_start_disabled: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_11]
    (wr_ctrl && !prog_enable_out && !start_reg) |=> !start_reg)
    else $error("start with programming disabled");

  // mode field behaviour
  a_mode_decode: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_01]
    lock_start_out |-> (locked_reg && mode_reg == fupc_pkg::FUPC_MODE_HARD_LOCK))
    else $error("lock mode mismatch");

  a_mode_frozen: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_01]
    start_reg |=> $stable(mode_reg))
    else $error("mode changed while busy");

  // hard-lock protection
  a_lock_sticky: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_10]
    $past(locked_reg) |-> locked_reg)
    else $error("lock released");

  a_no_erase_locked: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_10]
    $rose(erase_start_out) |-> !$past(locked_reg))
    else $error("erase after lock");

  a_no_relock: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_10]
    $rose(lock_start_out) |-> !$past(locked_reg))
    else $error("second lock launched");

  a_lock_cause: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_10]
    $rose(locked_reg) |-> ($past(wr_ctrl) &&
      $past(wr_mode) == fupc_pkg::FUPC_MODE_HARD_LOCK))
    else $error("lock set without lock write");

  // sector pointer halves are written independently
  a_sector_join: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_04]
    wr_high |=> sector_addr_out[15:8] == $past(reg_wdata_in))
    else $error("high byte");

  a_high_indep: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_04]
    wr_high |=> $stable(sector_addr_out[7:0]))
    else $error("high write touched low byte");

  a_sector_low: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_05]
    wr_low |=> sector_addr_out[7:0] == $past(reg_wdata_in))
    else $error("low byte");

  a_low_indep: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_05]
    wr_low |=> $stable(sector_addr_out[15:8]))
    else $error("low write touched high byte");

  // access qualifiers: register addressing and bank select
  a_mode_only_reg: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_09]
    (reg_wr_in && !reg_mode_in) |=> ($stable(key_val) && $stable(sector_addr_out)))
    else $error("non-register write landed");

  a_bank_only: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_09]
    (reg_wr_in && !bank1_sel_in) |=> ($stable(key_val) && $stable(sector_addr_out)))
    else $error("wrong bank write landed");

  a_read_unqual: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_09]
    (reg_rd_in && !reg_mode_in) |=> reg_rdata_out == '0)
    else $error("non-register read returned data");

  a_ctrl_no_key: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in) // [RULE_09]
    wr_ctrl |=> $stable(key_val))
    else $error("control write touched key");
endmodule
`default_nettype wire

/* File: verification/flash_user_program_control_tb.sv */
/*
  Self-checking bench for fupc_top: reset values, sector pointer, key,
  mode codes, start launch and auto clear, access qualifiers and lock.
  Assumes fupc_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_user_program_control_tb;
  logic ref_clk_in, rst_b_in, reg_wr_in, reg_rd_in, reg_mode_in, bank1_sel_in, flash_done_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, hi, lo, v;
  logic reg_hit_out, prog_enable_out, erase_start_out, lock_start_out, busy_out, locked_out;
  logic [15:0] sector_addr_out;
  logic [3:0] mode_out;
  logic [3:0] codes [6] = '{4'h5, 4'hA, 4'h3, 4'hF, 4'h0, 4'hA};
  integer seed = 44;
  int n_mismatch = 0;
  int comparisons = 0;
  fupc_top uut (.ref_clk_in, .rst_b_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_mode_in,
    .bank1_sel_in, .reg_wdata_in, .flash_done_in, .reg_rdata_out, .reg_hit_out,
    .sector_addr_out, .mode_out, .prog_enable_out, .erase_start_out, .lock_start_out,
    .busy_out, .locked_out);
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic md = 1, input logic bk = 1);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    reg_mode_in <= md;
    bank1_sel_in <= bk;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    reg_mode_in <= 1'b1;
    bank1_sel_in <= 1'b1;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    d = reg_rdata_out;
  endtask
  // expected {lock, erase} launch; lock blocks both once set
  function automatic logic [1:0] exp_launch(input logic [7:0] k, input logic [3:0] m, input logic lk);
    if (k != fupc_pkg::FUPC_KEY_ENABLE || lk) return 2'b00;
    if (m == fupc_pkg::FUPC_MODE_ERASE) return 2'b01;
    if (m == fupc_pkg::FUPC_MODE_HARD_LOCK) return 2'b10;
    return 2'b00;
  endfunction
  task automatic do_reset();
    @(posedge ref_clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    for (int a = 8'hEC; a <= 8'hEF; a++) begin
      rd(8'(a), v);
      check("reset reg", 8'h00, v);
    end
    check("reset ptr", 16'h0000, sector_addr_out);
    check("reset prog", 1'b0, prog_enable_out);
    check("reset lock", 1'b0, locked_out);
  endtask
  task automatic launch(input logic [7:0] k, input logic [3:0] m, input logic lk);
    logic [1:0] e;
    int n;
    e = exp_launch(k, m, lk);
    wr(fupc_pkg::FUPC_ADDR_KEY, k);
    check("prog_enable", k == fupc_pkg::FUPC_KEY_ENABLE, prog_enable_out);
    wr(fupc_pkg::FUPC_ADDR_CTRL, {m, 4'h1});
    check("mode", m, mode_out);
    check("start", e, {lock_start_out, erase_start_out});
    check("busy", e != 2'b00, busy_out);
    rd(fupc_pkg::FUPC_ADDR_CTRL, v);
    check("ctrl read", {m, 3'b000, e != 2'b00}, v);
    if ($random(seed) & 1) begin
      @(posedge ref_clk_in);
      flash_done_in <= 1'b1;
      @(posedge ref_clk_in);
      flash_done_in <= 1'b0;
    end
    // timeout is four cycles, so ten covers both endings
    for (n = 0; n < 10 && busy_out !== 1'b0; n++) @(posedge ref_clk_in);
    #1;
    rd(fupc_pkg::FUPC_ADDR_CTRL, v);
    check("auto clear", {m, 4'h0}, v);
  endtask
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    {reg_wr_in, reg_rd_in, flash_done_in, rst_b_in} = 4'h0;
    {reg_mode_in, bank1_sel_in} = 2'b11;
    {reg_addr_in, reg_wdata_in} = 16'h0000;
    repeat (2) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    do_reset();
    repeat (4) begin
      hi = $random(seed);
      lo = $random(seed);
      wr(fupc_pkg::FUPC_ADDR_SEC_HIGH, hi);
      wr(fupc_pkg::FUPC_ADDR_SEC_LOW, lo);
      check("pointer", {hi, lo}, sector_addr_out);
      rd(fupc_pkg::FUPC_ADDR_SEC_LOW, v);
      check("low read", lo, v);
      wr(fupc_pkg::FUPC_ADDR_SEC_HIGH, ~hi, 1'b0, 1'b1);
      wr(fupc_pkg::FUPC_ADDR_SEC_LOW, ~lo, 1'b1, 1'b0);
      check("qualified only", {hi, lo}, sector_addr_out);
    end
    rd(8'hF0, v);
    check("unmapped read", 8'h00, v);
    @(posedge ref_clk_in);
    reg_addr_in <= fupc_pkg::FUPC_ADDR_KEY;
    reg_rd_in <= 1'b1;
    reg_mode_in <= 1'b0;
    @(negedge ref_clk_in);
    check("hit unqualified", 1'b0, reg_hit_out);
    @(posedge ref_clk_in);
    reg_mode_in <= 1'b1;
    @(negedge ref_clk_in);
    check("hit qualified", 1'b1, reg_hit_out);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    foreach (codes[i]) launch(fupc_pkg::FUPC_KEY_ENABLE, codes[i], 1'b0);
    v = $random(seed);
    if (v == fupc_pkg::FUPC_KEY_ENABLE) v = 8'hA4;
    launch(v, fupc_pkg::FUPC_MODE_ERASE, 1'b0);
    launch(fupc_pkg::FUPC_KEY_ENABLE, fupc_pkg::FUPC_MODE_HARD_LOCK, 1'b0);
    check("locked", 1'b1, locked_out);
    launch(fupc_pkg::FUPC_KEY_ENABLE, fupc_pkg::FUPC_MODE_ERASE, 1'b1);
    do_reset();
    wrap_up();
  end
endmodule
`default_nettype wire
